// *** hw/umli_pkg.sv ***
package umli_pkg;

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] IRQ_EN_ADDR = 3'h1;
  localparam logic [2:0] MDM_CTL_ADDR = 3'h4;
  localparam logic [2:0] MDM_STAT_ADDR = 3'h6;
  localparam logic [2:0] SRC_ADDR = 3'h7;

  // ----------------------------------------
  // Modem control fields
  // ----------------------------------------
  localparam int MDM_CTL_W = 5;
  localparam int CTL_DTR = 0;
  localparam int CTL_RTS = 1;
  localparam int CTL_AUX1 = 2;
  localparam int CTL_AUX2 = 3;
  localparam int CTL_LOOP = 4;
  localparam logic [4:0] MDM_CTL_RST = 5'h00;

  // ----------------------------------------
  // Modem status fields
  // ----------------------------------------
  localparam int STAT_CTS_CHG = 0;
  localparam int STAT_DSR_CHG = 1;
  localparam int STAT_RI_TRAIL = 2;
  localparam int STAT_DCD_CHG = 3;
  localparam int STAT_CTS = 4;
  localparam logic [7:0] MDM_STAT_RST = 8'h00;

  // ----------------------------------------
  // Interrupt enable fields and sources
  // ----------------------------------------
  localparam int NSRC = 5;
  localparam int SRC_RDA = 0;
  localparam int SRC_TX = 1;
  localparam int SRC_RLS = 2;
  localparam int SRC_MDM = 3;
  localparam int SRC_TMO = 4;
  localparam int EN_UNIT = 6;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  // Bits 7 and 5 are not built and read as zero
  localparam logic [7:0] IRQ_EN_MASK = 8'h5f;

  // ----------------------------------------
  // Levels and timing
  // ----------------------------------------
  localparam int LVL_W = 7;
  localparam int TX_FIFO_DEPTH = 64;
  localparam logic [6:0] TX_REQ_LEVEL = 7'(TX_FIFO_DEPTH / 2);
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
  localparam int CHAR_W = 16;

  // ----------------------------------------
  // Signals from the rest of the serial port
  // ----------------------------------------
  typedef struct packed {
    logic fifo_mode;
    logic rx_buf_full;
    logic [6:0] rx_level;
    logic [6:0] trig_level;
    logic rx_push;
    logic rx_pop;
    logic rx_flush;
    logic lsr_read;
    logic irq_id_read;
    logic thr_write;
    logic thr_empty;
    logic [6:0] tx_level;
    logic [4:0] line_err;
    logic tx_serial;
    logic [15:0] char_cycles;
  } umli_core_s;

endpackage

// *** hw/umli_rx_timeout.sv ***
module umli_rx_timeout (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic rx_nonempty,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic rx_flush,
  input wire logic [15:0] char_cycles,
  output logic pending
);

  logic [15:0] cyc;
  logic [2:0] chars;
  logic restart;
  logic char_done;
  logic expired;
  logic [15:0] next_cyc;
  logic [2:0] next_chars;

  // ----------------------------------------
  // Restart and expiry
  // ----------------------------------------
  // restart source selection
  assign restart = rx_pop | rx_flush | (rx_push & ~pending) | ~enable;
  assign char_done = (cyc + 16'h0001 >= char_cycles);
  assign expired = enable & rx_nonempty & (chars == umli_pkg::TIMEOUT_CHARS);
  assign next_cyc = (restart | char_done) ? 16'h0000 : cyc + 16'h0001;
  assign next_chars = restart ? 3'h0 :
                      (char_done && chars != umli_pkg::TIMEOUT_CHARS) ? chars + 3'h1 : chars;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cyc <= 16'h0000;
      chars <= 3'h0;
    end else begin
      cyc <= next_cyc;
      chars <= next_chars;
    end
  end

  // ----------------------------------------
  // Pending flag
  // ----------------------------------------
  // cleared by read or flush
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pending <= 1'b0;
    end else if (rx_pop | rx_flush | ~enable) begin
      pending <= 1'b0;
    end else if (expired) begin
      pending <= 1'b1;
    end
  end

endmodule

// *** hw/umli_top.sv ***
// Notes on behaviour
// - Modem control bit 4 enables loop-back
// - Loop-back: tx pin high, tx feeds rx
// - Loop-back: cts pin ignored, rts pin high
// - Loop-back: low control bits drive status bits
// - Interrupts keep working in loop-back
// - Rts pin is inverse of control bit 1
// - Status bit 4 shows clear-to-send
// - Status bit 0 flags cts change, read-clears
// - Control and status reset to zero
// - Enable bit 6 makes port operate
// - Enable bits 4..0 gate five sources
// - Line errors raise line status source
// - Fifo mode: oldest char errors, read-clears
// - Non-fifo: errors of held character
// - Fifo mode: data source at trigger level
// - Non-fifo: data source while buffer full
// - Timeout after four idle character times
// - Timeout cleared by read or flush
// - Timeout restart depends on pending state
// - Only rts reaches a pin
// - Non-fifo tx request on empty holding
// - Fifo tx request at 32 or fewer
// - Modem source from any delta bit
module umli_top (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cts_n_pin,
  output logic rts_n_pin,
  input wire logic rxd_pin,
  output logic txd_pin,
  input wire umli_pkg::umli_core_s core,
  output logic rx_serial_in,
  output logic port_enable,
  output logic [4:0] irq_pending,
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [4:0] modem_control;
  logic [3:0] status_delta;
  logic [7:0] interrupt_enable;
  logic cts_meta;
  logic cts_sync;
  logic rxd_meta;
  logic rxd_sync;
  logic [3:0] line_prev;
  logic tx_cond_prev;
  logic rls_pend;
  logic tx_pend;
  logic tmo_pend;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic wr_irq_en;
  logic wr_mdm_ctl;
  logic rd_mdm_stat;
  logic loop_mode;
  logic unit_en;
  logic dtr;
  logic rts;
  logic aux_output_one;
  logic aux_output_two;
  logic [3:0] line_now;
  logic [3:0] delta_event;
  logic [7:0] modem_status;
  logic [4:0] src_now;
  logic [7:0] read_mux;
  logic rx_err_any;
  logic tx_cond;
  logic rda_now;
  logic fifo_on;

  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    // Set wins so an event in the clearing cycle survives
    sticky = set | (cur & ~clr);
  endfunction

  function automatic logic [3:0] sticky4(input logic [3:0] cur, input logic [3:0] set, input logic clr);
    sticky4 = set | (cur & {4{~clr}});
  endfunction

  assign wr_irq_en = reg_wr && reg_addr == umli_pkg::IRQ_EN_ADDR;
  assign wr_mdm_ctl = reg_wr && reg_addr == umli_pkg::MDM_CTL_ADDR;
  assign rd_mdm_stat = reg_rd && reg_addr == umli_pkg::MDM_STAT_ADDR;

  assign loop_mode = modem_control[umli_pkg::CTL_LOOP];
  assign unit_en = interrupt_enable[umli_pkg::EN_UNIT];
  assign dtr = modem_control[umli_pkg::CTL_DTR];
  assign rts = modem_control[umli_pkg::CTL_RTS];
  assign aux_output_one = modem_control[umli_pkg::CTL_AUX1];
  assign aux_output_two = modem_control[umli_pkg::CTL_AUX2];
  assign fifo_on = core.fifo_mode;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Idle level is high so reset leaves clear-to-send inactive
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      cts_meta <= cts_n_pin;
      cts_sync <= cts_meta;
      rxd_meta <= rxd_pin;
      rxd_sync <= rxd_meta;
    end
  end

  // ----------------------------------------
  // Modem lines seen by the status register
  // ----------------------------------------
  // Order is {dcd, ri, dsr, cts}
  // control bits drive status in loop
  // cts is inverted pin or rts bit
  // dtr and aux bits act only in loop
  assign line_now = loop_mode ? {aux_output_two, aux_output_one, dtr, rts} : {3'b000, ~cts_sync};

  assign delta_event[umli_pkg::STAT_CTS_CHG] = line_now[0] ^ line_prev[0];
  assign delta_event[umli_pkg::STAT_DSR_CHG] = line_now[1] ^ line_prev[1];
  // Ring indicator flags its trailing edge only
  assign delta_event[umli_pkg::STAT_RI_TRAIL] = ~line_now[2] & line_prev[2];
  assign delta_event[umli_pkg::STAT_DCD_CHG] = line_now[3] ^ line_prev[3];

  assign modem_status = {line_now, status_delta};

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      line_prev <= 4'h0;
    end else begin
      line_prev <= line_now;
    end
  end

  // read clears delta bits
  // A loop-back exit may leave stray deltas; software reads once to drop them
  // stray deltas cleared by read
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_delta <= umli_pkg::MDM_STAT_RST[3:0];
    end else begin
      status_delta <= sticky4(status_delta, delta_event & {4{unit_en}}, rd_mdm_stat);
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // control reset to zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      modem_control <= umli_pkg::MDM_CTL_RST;
    end else if (wr_mdm_ctl) begin
      modem_control <= reg_wdata[4:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      interrupt_enable <= umli_pkg::IRQ_EN_RST;
    end else if (wr_irq_en) begin
      interrupt_enable <= reg_wdata & umli_pkg::IRQ_EN_MASK;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  assign read_mux = (reg_addr == umli_pkg::IRQ_EN_ADDR) ? interrupt_enable :
                    (reg_addr == umli_pkg::MDM_CTL_ADDR) ? {3'b000, modem_control} :
                    (reg_addr == umli_pkg::MDM_STAT_ADDR) ? modem_status :
                    (reg_addr == umli_pkg::SRC_ADDR) ? {3'b000, irq_pending} : 8'h00;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? read_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Serial pins and loop-back path
  // ----------------------------------------
  // tx held high, tx looped into rx
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txd_pin <= 1'b1;
      rx_serial_in <= 1'b1;
    end else begin
      txd_pin <= (loop_mode || !unit_en) ? 1'b1 : core.tx_serial;
      // Break travels on the looped stream, so the receiver sees it
      rx_serial_in <= !unit_en ? 1'b1 : (loop_mode ? core.tx_serial : rxd_sync);
    end
  end

  // rts pin forced high in loop
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rts_n_pin <= 1'b1;
    end else begin
      rts_n_pin <= (loop_mode || !unit_en) ? 1'b1 : ~rts;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_enable <= 1'b0;
    end else begin
      port_enable <= unit_en;
    end
  end

  // ----------------------------------------
  // Receive line status source
  // ----------------------------------------
  // any of five error kinds
  assign rx_err_any = |core.line_err;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rls_pend <= 1'b0;
    end else if (!unit_en) begin
      rls_pend <= 1'b0;
    end else if (fifo_on) begin
      rls_pend <= sticky(rls_pend, rx_err_any, core.lsr_read);
    end else begin
      rls_pend <= rx_err_any;
    end
  end

  // ----------------------------------------
  // Receive data available source
  // ----------------------------------------
  // fifo fill at or above trigger
  assign rda_now = fifo_on ? (core.rx_level >= core.trig_level && core.rx_level != 7'h00) : core.rx_buf_full;

  // ----------------------------------------
  // Transmit request source
  // ----------------------------------------
  // non-fifo holding register empty
  // fifo 32 or fewer to send
  assign tx_cond = fifo_on ? (core.tx_level <= umli_pkg::TX_REQ_LEVEL) : core.thr_empty;

  // Raised on the edge so an identification read can drop it while empty
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tx_cond_prev <= 1'b0;
      tx_pend <= 1'b0;
    end else begin
      tx_cond_prev <= tx_cond & unit_en;
      tx_pend <= sticky(tx_pend, tx_cond & unit_en & ~tx_cond_prev,
                        core.irq_id_read | core.thr_write | ~unit_en);
    end
  end

  // ----------------------------------------
  // Receive timeout source
  // ----------------------------------------
  // timeout only in fifo mode
  umli_rx_timeout u_timeout (
    .core_clk(core_clk),
    .resetn(resetn),
    .enable(unit_en & fifo_on),
    .rx_nonempty(core.rx_level != 7'h00),
    .rx_push(core.rx_push),
    .rx_pop(core.rx_pop),
    .rx_flush(core.rx_flush),
    .char_cycles(core.char_cycles),
    .pending(tmo_pend)
  );

  // ----------------------------------------
  // Interrupt request
  // ----------------------------------------
  assign src_now[umli_pkg::SRC_RDA] = rda_now & unit_en;
  assign src_now[umli_pkg::SRC_TX] = tx_pend;
  assign src_now[umli_pkg::SRC_RLS] = rls_pend;
  // any delta bit raises modem source
  assign src_now[umli_pkg::SRC_MDM] = |status_delta;
  assign src_now[umli_pkg::SRC_TMO] = tmo_pend;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq_pending <= 5'h00;
      irq <= 1'b0;
    end else begin
      irq_pending <= src_now & interrupt_enable[4:0] & {5{unit_en}};
      irq <= unit_en & |(src_now & interrupt_enable[4:0]);
    end
  end

endmodule

// *** test/umli_chk.sv ***
module umli_chk (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cts_n_pin,
  input wire logic rts_n_pin,
  input wire logic rxd_pin,
  input wire logic txd_pin,
  input wire umli_pkg::umli_core_s core,
  input wire logic rx_serial_in,
  input wire logic port_enable,
  input wire logic [4:0] irq_pending,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Read data stands only in the answer cycle
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  AST_OFF_QUIET: assert property ((!port_enable) [*3] |->
    irq_pending == 5'h00 && !irq && rts_n_pin && txd_pin && rx_serial_in) else $error("unit off but active");
  AST_TXD_SRC: assert property (!txd_pin |-> !$past(core.tx_serial))
    else $error("transmit pin low without transmit data");
  AST_RTS_WRITE: assert property ($changed(rts_n_pin) |->
    $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("rts moved without write");
  AST_IRQ_SET: assert property ((irq_pending != 5'h00) [*2] |-> irq)
    else $error("irq low with source pending");
  AST_IRQ_CLR: assert property ((irq_pending == 5'h00) [*2] |-> !irq)
    else $error("irq high with nothing pending");
  AST_RDA_NF: assert property ((!core.fifo_mode && !core.rx_buf_full) [*2] |=>
    !irq_pending[umli_pkg::SRC_RDA]) else $error("data source without held character");
  AST_RDA_FF: assert property ((core.fifo_mode && core.rx_level < core.trig_level) [*2] |=>
    !irq_pending[umli_pkg::SRC_RDA]) else $error("data source below trigger");
  AST_RLS_NF: assert property ((!core.fifo_mode && core.line_err == 5'h00) [*2] |=>
    !irq_pending[umli_pkg::SRC_RLS]) else $error("line source without error");
  AST_TX_CLR: assert property (core.irq_id_read && !core.fifo_mode && $stable(core.thr_empty) ##1
    ($stable(core.thr_empty) && !core.fifo_mode) |=> !irq_pending[umli_pkg::SRC_TX]) else $error("tx source kept");
  cover property (port_enable && !rts_n_pin);
  cover property ($rose(irq_pending[umli_pkg::SRC_TMO]));
  cover property ($rose(irq_pending[umli_pkg::SRC_MDM]));
endmodule

bind umli_top umli_chk umli_chk_inst (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n_pin(cts_n_pin),
  .rts_n_pin(rts_n_pin), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .core(core), .rx_serial_in(rx_serial_in),
  .port_enable(port_enable), .irq_pending(irq_pending), .irq(irq));

// *** test/umli_modem.sv ***
module umli_modem (
  input wire logic core_clk,
  input wire logic [3:0] lag,
  input wire logic rts_n_pin,
  input wire logic txd_pin,
  output logic cts_n_pin,
  output logic rxd_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  initial begin
    cts_n_pin = 1'b1;
    rxd_pin = 1'b1;
  end
  // Echo the line back; answer rts with cts lag+1 cycles later, so slow sets can be modelled
  always @(posedge core_clk) begin
    rxd_pin <= txd_pin;
    if (cts_n_pin == rts_n_pin) cnt <= 4'h0;
    else if (cnt >= lag) cts_n_pin <= rts_n_pin;
    else cnt <= cnt + 4'h1;
  end
endmodule

// *** test/uart_modem_loopback_interrupts_bench.sv ***
module uart_modem_loopback_interrupts_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] lag = 4'h2;
  logic [7:0] reg_rdata, r;
  logic cts_n_pin, rts_n_pin, rxd_pin, txd_pin, rx_serial_in, port_enable, irq;
  logic [4:0] irq_pending;
  logic [15:0] qe;
  logic [15:0] exp_q[$];
  umli_pkg::umli_core_s core = '0;
  int fail_count = 0;
  int total_checks = 0;
  int i;

  always #5 core_clk = ~core_clk;

  umli_top umli_top_inst (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cts_n_pin(cts_n_pin), .rts_n_pin(rts_n_pin),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .core(core), .rx_serial_in(rx_serial_in),
    .port_enable(port_enable), .irq_pending(irq_pending), .irq(irq));
  umli_modem umli_modem_inst (.core_clk(core_clk), .lag(lag), .rts_n_pin(rts_n_pin), .txd_pin(txd_pin),
    .cts_n_pin(cts_n_pin), .rxd_pin(rxd_pin));

  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Expected value and compare mask are queued when the read is issued
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge core_clk);
    exp_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    case (k)
      0: core.rx_push <= 1'b1;
      1: core.rx_pop <= 1'b1;
      2: core.rx_flush <= 1'b1;
      3: core.lsr_read <= 1'b1;
      4: core.irq_id_read <= 1'b1;
      default: core.thr_write <= 1'b1;
    endcase
    @(posedge core_clk);
    {core.rx_push, core.rx_pop, core.rx_flush, core.lsr_read, core.irq_id_read, core.thr_write} <= 6'h00;
  endtask
  task automatic pend(input logic [4:0] e);
    cyc(3);
    chk("irq_pending", {3'h0, irq_pending}, {3'h0, e});
  endtask
  task automatic pin(input string n, input logic g, input logic e);
    chk(n, {7'h00, g}, {7'h00, e});
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Read answers arrive one cycle after the strobe
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      qe = exp_q.pop_front();
      chk("reg_rdata", reg_rdata & qe[15:8], qe[7:0]);
    end
  end

  initial begin
    #200000;
    fail_count++;
    end_sim();
  end

  initial begin
    void'($urandom(98));
    core.tx_serial = 1'b1;
    core.trig_level = 7'h08;
    core.char_cycles = 16'h0004;
    repeat (3) @(posedge core_clk);
    resetn <= 1'b1;
    rd(umli_pkg::MDM_CTL_ADDR, 8'h00, 8'hff);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h00, 8'hff);
    pin("rts_n_pin", rts_n_pin, 1'b1);
    pin("port_enable", port_enable, 1'b0);
    wr(umli_pkg::IRQ_EN_ADDR, 8'hff);
    rd(umli_pkg::IRQ_EN_ADDR, umli_pkg::IRQ_EN_MASK, 8'hff);
    pin("port_enable", port_enable, 1'b1);
    wr(umli_pkg::MDM_STAT_ADDR, 8'hff);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h00, 8'hff);
    rd(3'h0, 8'h00, 8'hff);
    // --------------------------------
    // Modem lines, prompt and slow set
    // --------------------------------
    wr(umli_pkg::MDM_CTL_ADDR, 8'h02);
    cyc(3);
    pin("rts_n_pin", rts_n_pin, 1'b0);
    cyc(12);
    pend(5'h08);
    pin("irq", irq, 1'b1);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h11, 8'hff);
    pend(5'h00);
    lag <= 4'h9;
    wr(umli_pkg::MDM_CTL_ADDR, 8'h00);
    cyc(3);
    pin("rts_n_pin", rts_n_pin, 1'b1);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h10, 8'hff);
    cyc(20);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h01, 8'hff);
    for (i = 0; i < 4; i++) begin
      r = 8'($urandom) & 8'h0f;
      wr(umli_pkg::MDM_CTL_ADDR, 8'h10 | r);
      cyc(4);
      pin("rts_n_pin", rts_n_pin, 1'b1);
      rd(umli_pkg::MDM_STAT_ADDR, {r[3], r[2], r[0], r[1], 4'h0}, 8'hf0);
    end
    core.tx_serial <= 1'b0;
    cyc(4);
    pin("txd_pin", txd_pin, 1'b1);
    pin("rx_serial_in", rx_serial_in, 1'b0);
    core.tx_serial <= 1'b1;
    wr(umli_pkg::MDM_CTL_ADDR, 8'h10);
    cyc(3);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h00, 8'h00);
    wr(umli_pkg::MDM_CTL_ADDR, 8'h11);
    pend(5'h08);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h22, 8'hff);
    wr(umli_pkg::MDM_CTL_ADDR, 8'h00);
    cyc(3);
    rd(umli_pkg::MDM_STAT_ADDR, 8'h00, 8'h00);
    core.tx_serial <= 1'b0;
    cyc(7);
    pin("txd_pin", txd_pin, 1'b0);
    pin("rx_serial_in", rx_serial_in, 1'b0);
    core.tx_serial <= 1'b1;
    core.rx_buf_full <= 1'b1;
    core.line_err <= 5'h01;
    core.thr_empty <= 1'b1;
    lag <= 4'h1;
    wr(umli_pkg::MDM_CTL_ADDR, 8'h02);
    cyc(12);
    for (i = 0; i < 6; i++) begin
      r = 8'($urandom) & 8'h1f;
      wr(umli_pkg::IRQ_EN_ADDR, 8'h40 | r);
      pend(r[4:0] & 5'h0f);
      pin("irq", irq, |r[3:0]);
      rd(umli_pkg::SRC_ADDR, r & 8'h0f, 8'hff);
    end
    wr(umli_pkg::IRQ_EN_ADDR, 8'h1f);
    core.line_err <= 5'h00;
    core.rx_buf_full <= 1'b0;
    pend(5'h00);
    pin("irq", irq, 1'b0);
    pin("rts_n_pin", rts_n_pin, 1'b1);
    pin("port_enable", port_enable, 1'b0);
    wr(umli_pkg::IRQ_EN_ADDR, 8'h42);
    for (i = 4; i < 6; i++) begin
      @(posedge core_clk) core.thr_empty <= 1'b0;
      @(posedge core_clk) core.thr_empty <= 1'b1;
      pend(5'h02);
      pulse(i);
      pend(5'h00);
    end
    core.fifo_mode <= 1'b1;
    core.tx_level <= 7'h21;
    core.rx_level <= 7'h07;
    wr(umli_pkg::IRQ_EN_ADDR, 8'h47);
    pend(5'h00);
    core.tx_level <= 7'h20;
    core.rx_level <= 7'h08;
    pend(5'h03);
    @(posedge core_clk) core.line_err <= 5'h04;
    @(posedge core_clk) core.line_err <= 5'h00;
    pend(5'h07);
    pulse(3);
    pend(5'h03);
    core.rx_level <= 7'h07;
    pend(5'h02);
    wr(umli_pkg::IRQ_EN_ADDR, 8'h50);
    pend(5'h10);
    pulse(2);
    pend(5'h00);
    core.rx_level <= 7'h01;
    pulse(0);
    cyc(10);
    pend(5'h00);
    cyc(8);
    pend(5'h10);
    pulse(0);
    pend(5'h10);
    pulse(1);
    pend(5'h00);
    cyc(8);
    pend(5'h00);
    cyc(8);
    pend(5'h10);
    end_sim();
  end
endmodule
